// >>> design/epmg_port.sv
// port m gpio top: axi4-lite registers, function multiplexer and pads
`default_nettype none

module epmg_port #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // power mode
   input wire logic stop_mode,
   // pins
   input wire logic [7:0] pin_in,
   output epmg_pkg::epmg_pad_t pad,
   // alternate-function peripherals
   input wire epmg_pkg::epmg_periph_out_t periph_out,
   output epmg_pkg::epmg_periph_in_t periph_in
);

   initial begin
      if (ADDR_W < 6 || ADDR_W > 32) $error("epmg_port address width out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0] pin_data_reg;
   logic [7:0] output_drive_enable;
   logic [7:0] alt_func_select_one;
   logic [7:0] alt_func_select_two;
   logic [7:0] alt_func_select_three;
   logic [7:0] open_drain_select;
   logic [7:0] pullup_select;
   logic [7:0] input_buffer_enable;
   logic [7:0] pin_sync;
   logic [7:0] pin_live;
   logic [7:0] alt_value;
   logic [7:0] alt_drive;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic wr_strb_reg;
   logic aw_full_reg, aw_full_next;
   logic w_full_reg, w_full_next;
   logic do_write;
   logic aw_take, w_take, ar_take;
   logic bvalid_next, rvalid_next;
   logic [31:0] rd_word;
   logic rd_hit;

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchroniser
   epmg_sync #(
      .WIDTH(epmg_pkg::PIN_W),
      .STAGES(2)
   ) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // only enabled input buffers pass the pin level inward
   assign pin_live = pin_sync & input_buffer_enable;

   ////////////////////////////////////////////////////////////////////////////
   // bus handshakes
   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   assign ar_take = arvalid & arready;
   assign do_write = aw_full_reg & w_full_reg & ~bvalid;

   // next state of the write and read channels
   always_comb begin
      aw_full_next = aw_full_reg ? ~do_write : aw_take;
      w_full_next = w_full_reg ? ~do_write : w_take;
      bvalid_next = do_write | (bvalid & ~bready);
      rvalid_next = ar_take | (rvalid & ~rready);
   end

   // address and data may arrive in either order
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         arready <= 1'b0;
         rvalid <= 1'b0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready <= ~aw_full_next & ~bvalid_next;
         wready <= ~w_full_next & ~bvalid_next;
         bvalid <= bvalid_next;
         arready <= ~rvalid_next;
         rvalid <= rvalid_next;
      end
   end

   // capture write address and data
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_addr_reg <= '0;
         wr_data_reg <= epmg_pkg::REG_RESET;
         wr_strb_reg <= 1'b0;
      end else begin
         if (aw_take) begin
            wr_addr_reg <= awaddr;
         end
         if (w_take) begin
            wr_data_reg <= wdata[7:0];
            wr_strb_reg <= wstrb[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes, only byte lane 0 carries bits
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_data_reg <= epmg_pkg::REG_RESET;
         output_drive_enable <= epmg_pkg::REG_RESET;
         alt_func_select_one <= epmg_pkg::REG_RESET;
         alt_func_select_two <= epmg_pkg::REG_RESET;
         alt_func_select_three <= epmg_pkg::REG_RESET;
         open_drain_select <= epmg_pkg::REG_RESET;
         pullup_select <= epmg_pkg::REG_RESET;
         input_buffer_enable <= epmg_pkg::REG_RESET;
      end else if (do_write && wr_strb_reg) begin
         unique case (wr_addr_reg)
            ADDR_W'(epmg_pkg::OFF_DATA): pin_data_reg <= wr_data_reg;
            ADDR_W'(epmg_pkg::OFF_OUTCTL): output_drive_enable <= wr_data_reg;
            ADDR_W'(epmg_pkg::OFF_FSEL1): alt_func_select_one <= wr_data_reg;
            ADDR_W'(epmg_pkg::OFF_FSEL2): begin
               alt_func_select_two <= wr_data_reg & epmg_pkg::FSEL2_MASK;
            end
            ADDR_W'(epmg_pkg::OFF_FSEL3): begin
               alt_func_select_three <= wr_data_reg & epmg_pkg::FSEL3_MASK;
            end
            ADDR_W'(epmg_pkg::OFF_ODRAIN): open_drain_select <= wr_data_reg;
            ADDR_W'(epmg_pkg::OFF_PULLUP): pullup_select <= wr_data_reg;
            ADDR_W'(epmg_pkg::OFF_INCTL): input_buffer_enable <= wr_data_reg;
            default: ;
         endcase
      end
   end

   // write response, error for unmapped addresses
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bresp <= epmg_pkg::RESP_OKAY;
      end else if (do_write) begin
         bresp <= rd_hit_w(wr_addr_reg) ? epmg_pkg::RESP_OKAY : epmg_pkg::RESP_SLVERR;
      end
   end

   // address decode shared by both directions
   function automatic logic rd_hit_w(input logic [ADDR_W-1:0] a);
      rd_hit_w = (a == ADDR_W'(epmg_pkg::OFF_DATA)) || (a == ADDR_W'(epmg_pkg::OFF_OUTCTL)) ||
                 (a == ADDR_W'(epmg_pkg::OFF_FSEL1)) || (a == ADDR_W'(epmg_pkg::OFF_FSEL2)) ||
                 (a == ADDR_W'(epmg_pkg::OFF_FSEL3)) || (a == ADDR_W'(epmg_pkg::OFF_ODRAIN)) ||
                 (a == ADDR_W'(epmg_pkg::OFF_PULLUP)) || (a == ADDR_W'(epmg_pkg::OFF_INCTL));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // read mux, upper bits always zero
   always_comb begin
      rd_word = '0;
      rd_hit = rd_hit_w(araddr);
      unique case (araddr)
         ADDR_W'(epmg_pkg::OFF_DATA): begin
            rd_word[7:0] = pin_live | (pin_data_reg & ~input_buffer_enable);
         end
         ADDR_W'(epmg_pkg::OFF_OUTCTL): rd_word[7:0] = output_drive_enable;
         ADDR_W'(epmg_pkg::OFF_FSEL1): rd_word[7:0] = alt_func_select_one;
         ADDR_W'(epmg_pkg::OFF_FSEL2): rd_word[7:0] = alt_func_select_two;
         ADDR_W'(epmg_pkg::OFF_FSEL3): rd_word[7:0] = alt_func_select_three;
         ADDR_W'(epmg_pkg::OFF_ODRAIN): rd_word[7:0] = open_drain_select;
         ADDR_W'(epmg_pkg::OFF_PULLUP): rd_word[7:0] = pullup_select;
         ADDR_W'(epmg_pkg::OFF_INCTL): rd_word[7:0] = input_buffer_enable;
         default: rd_word = '0;
      endcase
   end

   // read data register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= '0;
         rresp <= epmg_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rdata <= rd_word;
         rresp <= rd_hit ? epmg_pkg::RESP_OKAY : epmg_pkg::RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output multiplexer: port latch unless an output function owns the pin
   always_comb begin
      alt_value = pin_data_reg;
      alt_drive = 8'hFF;
      if (alt_func_select_one[epmg_pkg::PIN_SER2_CLK]) begin
         alt_value[epmg_pkg::PIN_SER2_CLK] = periph_out.serial_two_clock;
         alt_drive[epmg_pkg::PIN_SER2_CLK] = periph_out.serial_two_clock_oe;
      end
      if (alt_func_select_one[epmg_pkg::PIN_SER2_TX]) begin
         alt_value[epmg_pkg::PIN_SER2_TX] = periph_out.serial_two_transmit;
      end
      if (alt_func_select_one[epmg_pkg::PIN_SER3_CLK]) begin
         alt_value[epmg_pkg::PIN_SER3_CLK] = periph_out.serial_three_clock;
         alt_drive[epmg_pkg::PIN_SER3_CLK] = periph_out.serial_three_clock_oe;
      end
      if (alt_func_select_one[epmg_pkg::PIN_SER3_TX]) begin
         alt_value[epmg_pkg::PIN_SER3_TX] = periph_out.serial_three_transmit;
      end
      if (alt_func_select_two[epmg_pkg::PIN_ALARM]) begin
         alt_value[epmg_pkg::PIN_ALARM] = periph_out.alarm_output;
      end
      if (alt_func_select_two[epmg_pkg::PIN_TMR3]) begin
         alt_value[epmg_pkg::PIN_TMR3] = periph_out.timer_three_output;
      end
   end

   // pad drivers, output control still gates every driver
   epmg_pad u_pad (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .value(alt_value),
      .drive(output_drive_enable & alt_drive),
      .open_drain(open_drain_select),
      .pull_up(pullup_select),
      .pad(pad)
   );

   ////////////////////////////////////////////////////////////////////////////
   // inputs to the peripherals; interrupts ignore the function selects
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         periph_in <= '0;
      end else begin
         periph_in.ext_irq_three <= pin_live[epmg_pkg::PIN_IRQ3] & ~stop_mode;
         periph_in.ext_irq_two <= pin_live[epmg_pkg::PIN_IRQ2] & ~stop_mode;
         periph_in.serial_three_receive <= alt_func_select_one[epmg_pkg::PIN_SER3_RX]
            & pin_live[epmg_pkg::PIN_SER3_RX];
         periph_in.serial_three_clock <= alt_func_select_one[epmg_pkg::PIN_SER3_CLK]
            & pin_live[epmg_pkg::PIN_SER3_CLK];
         periph_in.serial_two_receive <= alt_func_select_one[epmg_pkg::PIN_SER2_RX]
            & pin_live[epmg_pkg::PIN_SER2_RX];
         periph_in.serial_two_clock <= alt_func_select_one[epmg_pkg::PIN_SER2_CLK]
            & pin_live[epmg_pkg::PIN_SER2_CLK];
         periph_in.timer_one_capture_one <= alt_func_select_two[epmg_pkg::PIN_CAP1]
            & pin_live[epmg_pkg::PIN_CAP1];
         periph_in.timer_one_capture_zero <= alt_func_select_two[epmg_pkg::PIN_CAP0]
            & pin_live[epmg_pkg::PIN_CAP0];
         periph_in.serial_three_clear_to_send <= alt_func_select_three[epmg_pkg::PIN_SERIAL_THREE_CLEAR_TO_SEND]
            & pin_live[epmg_pkg::PIN_SERIAL_THREE_CLEAR_TO_SEND];
         periph_in.serial_two_clear_to_send <= alt_func_select_three[epmg_pkg::PIN_SERIAL_TWO_CLEAR_TO_SEND]
            & pin_live[epmg_pkg::PIN_SERIAL_TWO_CLEAR_TO_SEND];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_both_held;
      aw_full_reg && w_full_reg && !bvalid;
   endsequence

   sequence s_read_of(logic [ADDR_W-1:0] a);
      ar_take && araddr == a;
   endsequence

   property p_drive_off;
      output_drive_enable == 8'h00 |=> pad.oe == 8'h00;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("pin driven while disabled");

   property p_port_latch;
      (alt_func_select_one | alt_func_select_two | alt_func_select_three) == 8'h00
         |=> pad.level == ($past(pin_data_reg) & ~$past(open_drain_select));
   endproperty
   a_port_latch: assert property (p_port_latch) else $error("port pin not from latch");

   property p_irq_three;
      input_buffer_enable[7] && !stop_mode && pin_sync[7] |=> periph_in.ext_irq_three;
   endproperty
   a_irq_three: assert property (p_irq_three) else $error("enabled pin missed irq");

   property p_write_drive;
      do_write && wr_strb_reg && wr_addr_reg == ADDR_W'(epmg_pkg::OFF_OUTCTL)
         |=> output_drive_enable == $past(wr_data_reg);
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("output control not written");

   property p_write_resp;
      s_both_held |=> bvalid ##0 !awready ##0 !wready;
   endproperty
   a_write_resp: assert property (p_write_resp) else $error("write response late");

   property p_upper_zero;
      s_read_of(ADDR_W'(epmg_pkg::OFF_DATA)) |=> rvalid && rdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("data upper bits not zero");

   property p_fsel2_zero;
      s_read_of(ADDR_W'(epmg_pkg::OFF_FSEL2)) |=> rdata[31:4] == 28'h0000000;
   endproperty
   a_fsel2_zero: assert property (p_fsel2_zero) else $error("select two reserved set");

   property p_fsel3_zero;
      s_read_of(ADDR_W'(epmg_pkg::OFF_FSEL3)) |=> rdata[3:1] == 3'h0 && rdata[31:5] == '0;
   endproperty
   a_fsel3_zero: assert property (p_fsel3_zero) else $error("select three reserved set");

   property p_open_drain;
      open_drain_select == 8'hFF |=> pad.level == 8'h00;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

   property p_tx3_route;
      alt_func_select_one[5] && output_drive_enable[5] && !open_drain_select[5]
         |=> pad.oe[5] && pad.level[5] == $past(periph_out.serial_three_transmit);
   endproperty
   a_tx3_route: assert property (p_tx3_route) else $error("transmit not on pin");

   property p_read_pins;
      s_read_of(ADDR_W'(epmg_pkg::OFF_DATA)) ##0 (input_buffer_enable == 8'hFF)
         |=> rdata[7:0] == $past(pin_sync);
   endproperty
   a_read_pins: assert property (p_read_pins) else $error("pin level not read");

endmodule

`default_nettype wire

// >>> design/epmg_pkg.sv
// constants, register map and carrier types of the port m gpio block
`default_nettype none

package epmg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_OUTCTL = 8'h04;
   localparam logic [7:0] OFF_FSEL1 = 8'h08;
   localparam logic [7:0] OFF_FSEL2 = 8'h0C;
   localparam logic [7:0] OFF_FSEL3 = 8'h10;
   localparam logic [7:0] OFF_ODRAIN = 8'h28;
   localparam logic [7:0] OFF_PULLUP = 8'h2C;
   localparam logic [7:0] OFF_INCTL = 8'h38;

   // widths, writable masks and reset value
   localparam int PIN_W = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] FSEL2_MASK = 8'h0F;
   localparam logic [7:0] FSEL3_MASK = 8'h11;

   // pin positions of the alternate functions
   localparam int PIN_SER2_CLK = 0;
   localparam int PIN_SER2_TX = 1;
   localparam int PIN_SER2_RX = 2;
   localparam int PIN_IRQ2 = 3;
   localparam int PIN_SER3_CLK = 4;
   localparam int PIN_SER3_TX = 5;
   localparam int PIN_SER3_RX = 6;
   localparam int PIN_IRQ3 = 7;
   localparam int PIN_CAP0 = 0;
   localparam int PIN_CAP1 = 1;
   localparam int PIN_ALARM = 2;
   localparam int PIN_TMR3 = 3;
   localparam int PIN_SERIAL_TWO_CLEAR_TO_SEND = 0;
   localparam int PIN_SERIAL_THREE_CLEAR_TO_SEND = 4;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // signals driven by the peripherals toward the pins
   typedef struct packed {
      logic serial_three_transmit;
      logic serial_two_transmit;
      logic serial_three_clock;
      logic serial_three_clock_oe;
      logic serial_two_clock;
      logic serial_two_clock_oe;
      logic timer_three_output;
      logic alarm_output;
   } epmg_periph_out_t;

   // signals handed from the pins to the peripherals
   typedef struct packed {
      logic ext_irq_three;
      logic ext_irq_two;
      logic serial_three_receive;
      logic serial_three_clock;
      logic serial_two_receive;
      logic serial_two_clock;
      logic timer_one_capture_one;
      logic timer_one_capture_zero;
      logic serial_three_clear_to_send;
      logic serial_two_clear_to_send;
   } epmg_periph_in_t;

   // pad controls
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
      logic [7:0] pull_up;
   } epmg_pad_t;

endpackage

`default_nettype wire

// >>> design/epmg_sync.sv
// two-stage synchroniser for the pin inputs
`default_nettype none

module epmg_sync #(
   parameter int WIDTH = 8,
   parameter int STAGES = 2
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   initial begin
      if (STAGES < 2) $error("epmg_sync needs at least two stages");
   end

   ////////////////////////////////////////////////////////////////////////////
   // one shift chain per bit, only the last stage is read
   genvar b;
   for (b = 0; b < WIDTH; b++) begin : g_bit
      logic [STAGES-1:0] chain_reg;
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            chain_reg <= '0;
         end else begin
            chain_reg <= {chain_reg[STAGES-2:0], async_in[b]};
         end
      end
      assign sync_out[b] = chain_reg[STAGES-1];
   end

endmodule

`default_nettype wire

// >>> design/epmg_pad.sv
// registered pad drivers with push-pull or open-drain per pin
`default_nettype none

module epmg_pad (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // per-pin controls
   input wire logic [7:0] value,
   input wire logic [7:0] drive,
   input wire logic [7:0] open_drain,
   input wire logic [7:0] pull_up,
   // pads
   output epmg_pkg::epmg_pad_t pad
);

   ////////////////////////////////////////////////////////////////////////////
   // per pin: open-drain only pulls low, push-pull drives both levels
   genvar i;
   for (i = 0; i < epmg_pkg::PIN_W; i++) begin : g_pin
      always_ff @(posedge sys_clk or negedge reset_n) begin
         if (!reset_n) begin
            pad.level[i] <= 1'b0;
            pad.oe[i] <= 1'b0;
            pad.pull_up[i] <= 1'b0;
         end else begin
            pad.level[i] <= value[i] & ~open_drain[i];
            pad.oe[i] <= drive[i] & (~open_drain[i] | ~value[i]);
            pad.pull_up[i] <= pull_up[i];
         end
      end
   end

endmodule

`default_nettype wire

// >>> tb/epmg_pins_model.sv
// pin world model: resolves each pad against pull-ups and outside drive
`default_nettype none
module epmg_pins_model (
   // pad controls from the port
   input wire epmg_pkg::epmg_pad_t pad,
   // level from the outside where nothing else drives
   input wire logic [7:0] ext_level,
   // resolved pin levels
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // driven pins follow the pad, released ones the pull-up or outside
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad.oe[i]) pin_in[i] = pad.level[i];
         else if (pad.pull_up[i]) pin_in[i] = 1'b1;
         else pin_in[i] = ext_level[i];
      end
   end
endmodule
`default_nettype wire

// >>> tb/test_eight_bit_port_m_gpio.sv
// self-checking bench for the port m gpio block
`default_nettype none
module test_eight_bit_port_m_gpio;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] OFS [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28, 8'h2C, 8'h38};
   localparam logic [7:0] MSK [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h11, 8'hFF, 8'hFF, 8'hFF};
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, ext_level = 8'h00, pin_in;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic stop_mode = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   epmg_pkg::epmg_pad_t pad;
   epmg_pkg::epmg_periph_out_t po = '0;
   epmg_pkg::epmg_periph_in_t pi;
   int failures = 0, check_count = 0;
   always #5 sys_clk = ~sys_clk;
   // design and pin world
   epmg_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .stop_mode(stop_mode), .pin_in(pin_in), .pad(pad), .periph_out(po), .periph_in(pi));
   epmg_pins_model pins_u (.pad(pad), .ext_level(ext_level), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////////
   // compare, bus cycles, settling
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 60);
      bready <= 1'b0;
      r = bresp;
      chk(32'(n < 60), 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 60);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      chk(32'(n < 60), 32'h1);
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk(32'(r), 32'(epmg_pkg::RESP_OKAY));
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d, exp);
      chk(32'(r), 32'(epmg_pkg::RESP_OKAY));
   endtask
   task automatic settle();
      repeat (6) @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      for (int i = 0; i < 8; i++) rc(OFS[i], 32'h0);
      chk(32'({pad.oe, pad.pull_up, pi}), 32'h0);
      $display("reset test done");
   endtask
   task automatic t_regs();
      for (int i = 0; i < 8; i++) begin
         w(OFS[i], 32'hFFFFFFFF);
         rc(OFS[i], {24'h0, MSK[i]});
         w(OFS[i], 32'h0);
      end
      $display("register test done");
   endtask
   task automatic t_bad();
      logic [31:0] d;
      logic [1:0] r;
      wr(8'h14, 32'hFF, r);
      chk(32'(r), 32'(epmg_pkg::RESP_SLVERR));
      rd(8'h14, d, r);
      chk({d[31:2], r}, {30'h0, epmg_pkg::RESP_SLVERR});
      $display("unmapped test done");
   endtask
   task automatic t_out();
      w(8'h04, 32'h0F);
      w(8'h00, 32'hA5);
      settle();
      chk(32'({pad.oe, pad.level & pad.oe}), 32'h0F05);
      w(8'h28, 32'h0F);
      w(8'h2C, 32'hFF);
      settle();
      chk(32'({pad.oe, pad.level, pad.pull_up}), 32'h0AA0FF);
      w(8'h28, 32'h0);
      w(8'h2C, 32'h0);
      w(8'h04, 32'h0);
      $display("output test done");
   endtask
   task automatic t_in();
      @(posedge sys_clk);
      ext_level <= 8'h88;
      w(8'h38, 32'hFF);
      settle();
      rc(8'h00, 32'h88);
      chk(32'({pi.ext_irq_three, pi.ext_irq_two}), 32'h3);
      stop_mode <= 1'b1;
      settle();
      chk(32'({pi.ext_irq_three, pi.ext_irq_two}), 32'h0);
      stop_mode <= 1'b0;
      w(8'h38, 32'h0); // all eight input buffers switched off again
      settle();
      rc(8'h00, 32'hA5);
      chk(32'({pi.ext_irq_three, pi.ext_irq_two}), 32'h0);
      $display("input test done");
   endtask
   task automatic t_alt();
      @(posedge sys_clk);
      po <= '{serial_three_transmit: 1'b1, timer_three_output: 1'b1, alarm_output: 1'b1,
              default: 1'b0};
      ext_level <= 8'h51;
      w(8'h00, 32'h0);
      // selects kept apart: no pin set in two of them
      w(8'h08, 32'h60);
      w(8'h0C, 32'h0C);
      w(8'h10, 32'h11);
      w(8'h04, 32'h2C);
      w(8'h38, 32'h51);
      settle();
      chk(32'(pad.level & 8'h2C), 32'h2C);
      chk(32'({pi.serial_three_receive, pi.serial_three_clear_to_send,
               pi.serial_two_clear_to_send}), 32'h7);
      w(8'h08, 32'h0);
      w(8'h0C, 32'h0);
      w(8'h10, 32'h0);
      settle();
      chk(32'(pad.level & 8'h2C), 32'h0);
      chk(32'({pi.serial_three_receive, pi.serial_three_clear_to_send}), 32'h0);
      // captures: pin 0 enabled and high, pin 1 input disabled
      w(8'h0C, 32'h03);
      settle();
      chk(32'({pi.timer_one_capture_one, pi.timer_one_capture_zero}), 32'h1);
      w(8'h0C, 32'h0);
      $display("alternate test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // verdict, main sequence, watchdog
   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset();
      t_regs();
      t_bad();
      t_out();
      t_in();
      t_alt();
      wrap_up();
   end
   initial begin
      #300000;
      failures++;
      wrap_up();
   end
endmodule
`default_nettype wire
